//--- rtl/trsc_pkg.sv
// Constants for the top-of-stack register cache.
// Assumes one clock, synchronous active-low reset and an APB master.
package trsc_pkg;
  localparam int DW = 16;
  localparam int AW = 8;
  // Store field codes
  localparam logic [4:0] ST_PUSH = 5'h08;
  localparam logic [4:0] ST_MARKER_UP = 5'h0b;
  localparam logic [4:0] ST_SLOT_LO = 5'h18;
  // Special field codes
  localparam logic [4:0] SP_COUNT_INC = 5'h08;
  localparam logic [4:0] SP_COUNT_DEC = 5'h09;
  localparam logic [4:0] SP_POP = 5'h17;
  // S-bus field codes
  localparam logic [4:0] SB_MARKER_DOWN = 5'h08;
  localparam logic [4:0] SB_SLOT_LO = 5'h18;
  // R-bus field codes
  localparam logic [3:0] RB_SLOT_LO = 4'h8;
  localparam logic [3:0] RB_SLOT_HI = 4'ha;
  // Register map (byte addresses)
  localparam logic [AW-1:0] ADDR_COUNT = 8'h00;
  localparam logic [AW-1:0] ADDR_STACK_TOP = 8'h04;
  localparam logic [AW-1:0] ADDR_SLOT0 = 8'h08;
  localparam logic [AW-1:0] ADDR_SLOT3 = 8'h14;
  localparam int NAME_LSB = 4;
  localparam logic [2:0] COUNT_MAX = 3'h4;
  localparam logic [2:0] COUNT_RST = 3'h0;
  localparam logic [1:0] NAME_RST = 2'h0;
  localparam logic [DW-1:0] STACK_TOP_RST = 16'h0000;
endpackage : trsc_pkg

//--- rtl/trsc_top.sv
// Top-of-stack register cache: four renamed slots, count and stack top.
// Assumes microinstruction fields are valid every clock; APB zero-wait.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module trsc_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [trsc_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] storeCode,
  input wire logic [4:0] specialCode,
  input wire logic [4:0] sBusSel,
  input wire logic [3:0] rBusSel,
  input wire logic [trsc_pkg::DW-1:0] storeBus,
  output logic [trsc_pkg::DW-1:0] rBusReg,
  output logic [trsc_pkg::DW-1:0] sBusReg,
  output logic [trsc_pkg::DW-1:0] memoryStackTop,
  output logic [2:0] cachedCount
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [trsc_pkg::DW-1:0] slotQ [4];
  logic [2:0] countQ;
  logic [1:0] nameQ;
  logic [1:0] tmpBaseQ;
  logic tmpValidQ;
  logic [trsc_pkg::DW-1:0] stackTopQ;
  logic [trsc_pkg::DW-1:0] rBusQ;
  logic [trsc_pkg::DW-1:0] sBusQ;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire isPush = storeCode == trsc_pkg::ST_PUSH;
  wire isUp = storeCode == trsc_pkg::ST_MARKER_UP;
  wire isPop = specialCode == trsc_pkg::SP_POP;
  wire isInc = specialCode == trsc_pkg::SP_COUNT_INC;
  wire isDec = specialCode == trsc_pkg::SP_COUNT_DEC;
  wire isDown = sBusSel == trsc_pkg::SB_MARKER_DOWN;
  wire stSlot = storeCode[4:2] == trsc_pkg::ST_SLOT_LO[4:2];
  wire sbSlot = sBusSel[4:2] == trsc_pkg::SB_SLOT_LO[4:2];
  wire rbSlot = rBusSel >= trsc_pkg::RB_SLOT_LO &&
    rBusSel <= trsc_pkg::RB_SLOT_HI;
  wire [1:0] tempName = nameQ + countQ[1:0];
  wire [1:0] lowSlot = tempName - 2'h1;
  wire [1:0] readBase = tmpValidQ ? tmpBaseQ : nameQ;
  wire [1:0] storeBase = isDown ? tempName : nameQ;
  wire [1:0] pushIdx = nameQ + 2'h3;
  wire [1:0] stIdx = storeBase + ~storeCode[1:0];
  wire [1:0] sIdx = readBase + ~sBusSel[1:0];
  wire [1:0] rIdx = readBase + ~rBusSel[1:0];
  wire slotWr = isPush | isUp | stSlot;
  wire [1:0] slotIdx = isPush ? pushIdx :
    (isUp ? tempName : stIdx);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire apbAcc = psel & penable;
  wire hitCount = paddr == trsc_pkg::ADDR_COUNT;
  wire hitTop = paddr == trsc_pkg::ADDR_STACK_TOP;
  wire hitSlot = paddr >= trsc_pkg::ADDR_SLOT0 &&
    paddr <= trsc_pkg::ADDR_SLOT3 && paddr[1:0] == 2'h0;
  wire [1:0] apbSlot = 2'(paddr[3:2] - trsc_pkg::ADDR_SLOT0[3:2]);
  wire mapped = hitCount | hitTop | hitSlot;
  wire wrCount = apbAcc & pwrite & hitCount;
  wire wrTop = apbAcc & pwrite & hitTop;
  wire [2:0] wrCountVal = pwdata[2:0] > trsc_pkg::COUNT_MAX ?
    trsc_pkg::COUNT_MAX : pwdata[2:0];
  wire [31:0] rdCount = {26'h0, nameQ, 1'b0, countQ};
  wire [31:0] rdData = hitCount ? rdCount :
    (hitTop ? {16'h0, stackTopQ} :
    (hitSlot ? {16'h0, slotQ[apbSlot]} : 32'h0));
  assign pready = 1'b1;
  assign pslverr = apbAcc & ~mapped;
  assign prdata = rdData;

  // ----------------------------------------------------------------
  // Count and names
  // ----------------------------------------------------------------
  wire cntUp = (isPush | isInc) & ~(isPop | isDec);
  wire cntDn = (isPop | isDec) & ~(isPush | isInc);
  logic [2:0] countD;
  logic [1:0] nameD;
  always_comb
  begin
    countD = countQ;
    if (wrCount)
    begin
      countD = wrCountVal;
    end
    else if (cntUp && countQ != trsc_pkg::COUNT_MAX)
    begin
      countD = countQ + 3'h1;
    end
    else if (cntDn && countQ != 3'h0)
    begin
      countD = countQ - 3'h1;
    end
    nameD = nameQ;
    if (isPush)
    begin
      nameD = nameQ - 2'h1;
    end
    else if (isPop)
    begin
      nameD = nameQ + 2'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      countQ <= trsc_pkg::COUNT_RST;
      nameQ <= trsc_pkg::NAME_RST;
      tmpValidQ <= 1'b0;
      tmpBaseQ <= trsc_pkg::NAME_RST;
    end
    else
    begin
      countQ <= countD;
      nameQ <= nameD;
      tmpValidQ <= isUp;
      tmpBaseQ <= tempName;
    end
  end

  // ----------------------------------------------------------------
  // Slots, stack top and bus registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      slotQ <= '{default: '0};
    end
    else if (slotWr)
    begin
      slotQ[slotIdx] <= storeBus;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      stackTopQ <= trsc_pkg::STACK_TOP_RST;
    end
    else if (wrTop)
    begin
      stackTopQ <= pwdata[trsc_pkg::DW-1:0];
    end
    else if (isUp)
    begin
      stackTopQ <= stackTopQ - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rBusQ <= '0;
      sBusQ <= '0;
    end
    else
    begin
      if (rbSlot)
      begin
        rBusQ <= slotQ[rIdx];
      end
      if (isDown)
      begin
        sBusQ <= slotQ[lowSlot];
      end
      else if (sbSlot)
      begin
        sBusQ <= slotQ[sIdx];
      end
    end
  end

  assign rBusReg = rBusQ;
  assign sBusReg = sBusQ;
  assign memoryStackTop = stackTopQ;
  assign cachedCount = countQ;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wire quiet = ~wrCount & ~wrTop;

  property p_count_range;
    @(posedge sys_clk) disable iff (!rst_n)
    countQ <= trsc_pkg::COUNT_MAX;
  endproperty
  a_count_range: assert property (p_count_range)
    else $error("cached count above four");

  property p_push_count;
    @(posedge sys_clk) disable iff (!rst_n)
    (isPush && !isPop && !isDec && quiet && countQ < 3'h4)
      |=> countQ == $past(countQ) + 3'h1;
  endproperty
  a_push_count: assert property (p_push_count)
    else $error("push did not raise count");

  property p_push_name;
    @(posedge sys_clk) disable iff (!rst_n)
    isPush |=> nameQ == 2'($past(nameQ) - 2'h1);
  endproperty
  a_push_name: assert property (p_push_name)
    else $error("push rotation wrong");

  property p_push_data;
    @(posedge sys_clk) disable iff (!rst_n)
    isPush |=> slotQ[nameQ] == $past(storeBus);
  endproperty
  a_push_data: assert property (p_push_data)
    else $error("pushed value is not on top");

  property p_pop;
    @(posedge sys_clk) disable iff (!rst_n)
    (isPop && !isPush && !isInc && quiet && countQ != 3'h0)
      |=> countQ == $past(countQ) - 3'h1 &&
        nameQ == 2'($past(nameQ) + 2'h1);
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop count or rotation wrong");

  property p_up_top;
    @(posedge sys_clk) disable iff (!rst_n)
    (isUp && !wrTop) |=> stackTopQ == $past(stackTopQ) - 16'h0001;
  endproperty
  a_up_top: assert property (p_up_top)
    else $error("stack top did not drop");

  property p_up_slot;
    @(posedge sys_clk) disable iff (!rst_n)
    isUp |=> slotQ[$past(tempName)] == $past(storeBus) && tmpValidQ;
  endproperty
  a_up_slot: assert property (p_up_slot)
    else $error("marker-up slot wrong");

  property p_down_src;
    @(posedge sys_clk) disable iff (!rst_n)
    isDown |=> sBusQ == $past(slotQ[lowSlot]);
  endproperty
  a_down_src: assert property (p_down_src)
    else $error("marker-down source wrong");

  property p_down_revert;
    @(posedge sys_clk) disable iff (!rst_n)
    (isDown && !isUp) |=> !tmpValidQ;
  endproperty
  a_down_revert: assert property (p_down_revert)
    else $error("names not restored after marker-down");

  property p_empty;
    @(posedge sys_clk) disable iff (!rst_n)
    (countQ == 3'h0 && !cntUp && !wrCount) |=> countQ == 3'h0;
  endproperty
  a_empty: assert property (p_empty)
    else $error("count left zero without increment");

  property p_down_store;
    @(posedge sys_clk) disable iff (!rst_n)
    (isDown && storeCode == trsc_pkg::ST_SLOT_LO)
      |=> slotQ[$past(lowSlot)] == $past(storeBus);
  endproperty
  a_down_store: assert property (p_down_store)
    else $error("store beside marker-down missed temporary name");

  property p_scratch_store;
    @(posedge sys_clk) disable iff (!rst_n)
    (storeCode == trsc_pkg::ST_SLOT_LO && !isDown)
      |=> slotQ[2'($past(nameQ) - 2'h1)] == $past(storeBus);
  endproperty
  a_scratch_store: assert property (p_scratch_store)
    else $error("store field missed the slot named fourth");

  property p_read_temp;
    @(posedge sys_clk) disable iff (!rst_n)
    (tmpValidQ && sBusSel == trsc_pkg::SB_SLOT_LO + 5'h3)
      |=> sBusQ == $past(slotQ[tmpBaseQ]);
  endproperty
  a_read_temp: assert property (p_read_temp)
    else $error("read after marker-up ignored temporary name");

  property p_read_rd;
    @(posedge sys_clk) disable iff (!rst_n)
    (!tmpValidQ && rBusSel == trsc_pkg::RB_SLOT_LO)
      |=> rBusQ == $past(slotQ[2'(nameQ - 2'h1)]);
  endproperty
  a_read_rd: assert property (p_read_rd)
    else $error("r bus read missed the slot named fourth");

  property p_name_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (!isPush && !isPop) |=> nameQ == $past(nameQ);
  endproperty
  a_name_hold: assert property (p_name_hold)
    else $error("names moved without push or pop");
endmodule : trsc_top

//--- verification/tos_register_stack_cache_tb.sv
// Self-checking bench: random stack traffic against a reference model.
// Assumes trsc_top with a zero-wait APB slave and one 125 MHz clock.
`timescale 1ns/100ps
module tos_register_stack_cache_tb;
  logic sysClk, rstN, psel, penable, pwrite, pready, pslverr, tmpV, chkOn;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] storeCode, specialCode, sBusSel;
  logic [3:0] rBusSel;
  logic [15:0] storeBus, rBusReg, sBusReg, memoryStackTop, opData;
  logic [15:0] top, expS, expR, v;
  logic [15:0] slot [4];
  logic [2:0] opKind, cachedCount, cnt, k;
  logic [1:0] namer, tmpN;
  logic err;
  integer seed, nMismatch, samplesChecked, i;
  integer cyc = 0;
  trsc_top dut (.sys_clk(sysClk), .rst_n(rstN), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .storeCode(storeCode), .specialCode(specialCode), .sBusSel(sBusSel),
    .rBusSel(rBusSel), .storeBus(storeBus), .rBusReg(rBusReg),
    .sBusReg(sBusReg), .memoryStackTop(memoryStackTop),
    .cachedCount(cachedCount));
  trsc_seq_model partner (.opKind(opKind), .opData(opData),
    .storeCode(storeCode), .specialCode(specialCode), .sBusSel(sBusSel),
    .rBusSel(rBusSel), .storeBus(storeBus));
  initial
  begin
    sysClk = 1'b0;
    forever #4 sysClk = ~sysClk;
  end
  task automatic wrapUp();
    $display("Checked %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrapUp
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      nMismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  always @(posedge sysClk)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      nMismatch++;
      wrapUp();
    end
  end
  always @(negedge sysClk)
    if (chkOn)
    begin
      chk("count", {29'h0, cnt}, {29'h0, cachedCount});
      chk("stack top", {16'h0, top}, {16'h0, memoryStackTop});
      chk("s bus", {16'h0, expS}, {16'h0, sBusReg});
      chk("r bus", {16'h0, expR}, {16'h0, rBusReg});
    end
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge sysClk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sysClk);
    penable <= 1'b1;
    @(posedge sysClk);
    while (pready !== 1'b1)
    begin
      @(posedge sysClk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("register", e, rd);
  endtask : rchk
  task automatic op(input logic [2:0] kd, input logic [15:0] d);
    logic [1:0] b, ix, rn;
    opKind <= kd;
    opData <= d;
    @(posedge sysClk);
    b = tmpV ? tmpN : namer;
    rn = d[1] ? 2'h2 : {1'b0, d[0]};
    ix = kd == 3'h6 ? namer + 2'h3 - d[1:0] :
      kd == 3'h4 || kd == 3'h7 ? namer + cnt[1:0] - 2'h1 :
      kd == 3'h3 ? namer + cnt[1:0] : namer + 2'h3;
    if (kd == 3'h4 || kd == 3'h7)
      expS = slot[ix];
    if (kd == 3'h1 || kd == 3'h3 || kd == 3'h6 || kd == 3'h7)
      slot[ix] = d;
    if (kd == 3'h5)
      expS = slot[b + 2'h3 - d[1:0]];
    if (kd == 3'h5)
      expR = slot[b + 2'h3 - rn];
    tmpV = kd == 3'h3;
    tmpN = ix;
    if (kd == 3'h1)
      namer = ix;
    if (kd == 3'h2)
      namer = namer + 2'h1;
    if (kd == 3'h3)
      top = top - 16'h1;
    if (kd == 3'h1 || kd == 3'h3)
      cnt = cnt + 3'h1;
    if (kd == 3'h2 || kd == 3'h4 || kd == 3'h7)
      cnt = cnt - 3'h1;
  endtask : op
  initial
  begin
    seed = 33;
    {nMismatch, samplesChecked} = 64'h0;
    {chkOn, rstN, psel, penable, pwrite, tmpV} = 6'h0;
    {paddr, pwdata, opKind, opData} = 59'h0;
    {cnt, namer, tmpN, top, expS, expR} = 55'h0;
    for (i = 0; i < 4; i++)
      slot[i] = 16'h0;
    repeat (2) @(posedge sysClk);
    rstN <= 1'b1;
    chkOn = 1'b1;
    for (i = 0; i < 4; i++)
      rchk(8'(8'h08 + 4 * i), 32'h0);
    v = 16'($random(seed));
    apb(1'b1, 8'h04, {16'h0, v});
    top = v;
    rchk(8'h04, {16'h0, v});
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    for (i = 0; i < 4; i++)
      op(3'h1, 16'($random(seed)));
    for (i = 0; i < 4; i++)
      op(3'h5, 16'(i));
    op(3'h4, 16'h0);
    op(3'h3, 16'($random(seed)));
    op(3'h5, 16'h3);
    op(3'h7, 16'($random(seed)));
    op(3'h6, 16'h0);
    op(3'h5, 16'h0);
    for (i = 0; i < 60; i++)
    begin
      k = 3'($unsigned($random(seed)) % 7) + 3'h1;
      if ((k == 3'h1 || k == 3'h3 || k == 3'h6) && cnt == 3'h4)
        k = 3'h2;
      if ((k == 3'h2 || k == 3'h4 || k == 3'h7) && cnt == 3'h0)
        k = 3'h1;
      v = 16'($random(seed));
      if (k == 3'h6)
        v[1:0] = 2'h3 - cnt[1:0];
      op(k, v);
    end
    op(3'h0, 16'h0);
    for (i = 0; i < 4; i++)
      rchk(8'(8'h08 + 4 * i), {16'h0, slot[i]});
    rchk(8'h00, {26'h0, namer, 1'b0, cnt});
    apb(1'b1, 8'h00, 32'h7);
    cnt = 3'h4;
    rchk(8'h00, {26'h0, namer, 1'b0, cnt});
    wrapUp();
  end
endmodule : tos_register_stack_cache_tb

//--- verification/trsc_seq_model.sv
// Sequencer stand-in: expands one operation kind into microinstruction fields.
// Assumes the bench changes opKind and opData just after a rising edge.
`timescale 1ns/100ps
module trsc_seq_model (
  input wire logic [2:0] opKind,
  input wire logic [15:0] opData,
  output logic [4:0] storeCode,
  output logic [4:0] specialCode,
  output logic [4:0] sBusSel,
  output logic [3:0] rBusSel,
  output logic [15:0] storeBus
);
  wire logic isRead = opKind == 3'h5;
  wire logic isDown = opKind == 3'h4 || opKind == 3'h7;
  wire logic isStore = opKind == 3'h1 || opKind == 3'h3 ||
    opKind[2:1] == 2'h3;
  // Kind 6 is a scratch store, kind 7 a marker-down with a store of RD
  assign storeCode = opKind == 3'h1 ? trsc_pkg::ST_PUSH :
    opKind == 3'h3 ? trsc_pkg::ST_MARKER_UP :
    opKind == 3'h6 ? trsc_pkg::ST_SLOT_LO + {3'h0, opData[1:0]} :
    opKind == 3'h7 ? trsc_pkg::ST_SLOT_LO : 5'h1f;
  // Marker moves always carry their count adjust
  assign specialCode = opKind == 3'h2 ? trsc_pkg::SP_POP :
    opKind == 3'h3 ? trsc_pkg::SP_COUNT_INC :
    isDown ? trsc_pkg::SP_COUNT_DEC : 5'h1f;
  assign sBusSel = isDown ? trsc_pkg::SB_MARKER_DOWN :
    isRead ? trsc_pkg::SB_SLOT_LO + {3'h0, opData[1:0]} : 5'h1f;
  assign rBusSel = isRead ?
    trsc_pkg::RB_SLOT_LO + {2'h0, opData[1], opData[0] & ~opData[1]} : 4'hf;
  // Bus not driven by a store shows a changing pattern
  assign storeBus = isStore ? opData : ~opData;
endmodule : trsc_seq_model
